/* File: shared/rtcx_pkg.sv */
// rtcx_pkg: constants and carrier types for the rtc oscillator register block
// assumes a 100 MHz system clock and an ahb-lite register bus of 32-bit words
package rtcx_pkg;

    // clock and load-capacitance stepping pace
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned CAP_STEP_TIME_NS = 1000;
    localparam int unsigned CAP_STEP_CYCLES  =
        (CAP_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CNT_W       = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CAPTURE_BYTE0   = 8'h00;
    localparam logic [7:0] IDX_TIMER_CAPTURE_BYTE1   = 8'h01;
    localparam logic [7:0] IDX_TIMER_CAPTURE_BYTE2   = 8'h02;
    localparam logic [7:0] IDX_TIMER_CAPTURE_BYTE3   = 8'h03;
    localparam logic [7:0] IDX_TIMER_CMD  = 8'h04;
    localparam logic [7:0] IDX_OSC_CTRL   = 8'h05;
    localparam logic [7:0] IDX_OSC_CFG    = 8'h06;
    localparam logic [7:0] IDX_OSC_PIN    = 8'h07;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h11;

    // timer command register fields
    localparam int unsigned CMD_SET_BIT = 1;
    localparam int unsigned CMD_CAP_BIT = 0;

    // oscillator control fields
    localparam int unsigned CTRL_GAIN_BIT  = 7;
    localparam int unsigned CTRL_CRYSTAL_MODE_SELECT_BIT = 6;
    localparam int unsigned CTRL_BIAS_BIT  = 5;
    localparam int unsigned CTRL_VALID_BIT = 4;
    localparam int unsigned CTRL_LFO_BIT   = 3;

    // oscillator configuration fields
    localparam int unsigned CFG_STEP_BIT  = 7;
    localparam int unsigned CFG_READY_BIT = 6;
    localparam int unsigned CFG_CAP_MSB   = 3;
    localparam int unsigned CFG_CAP_W     = 4;

    // pin configuration fields
    localparam int unsigned PIN_SHORT_BIT = 7;
    localparam int unsigned PIN_RSVD_W    = 7;

    // reset values
    localparam logic [7:0] RST_CAPTURE  = 8'h00;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [3:0] RST_LOAD_CAP = 4'h0;
    localparam logic [6:0] RST_PIN_RSVD = 7'h00;
    localparam logic [3:0] RST_IRQ      = 4'h0;

    // interrupt event bits
    localparam int unsigned EVT_SET_DONE  = 0;
    localparam int unsigned EVT_CAP_DONE  = 1;
    localparam int unsigned EVT_CAP_READY = 2;
    localparam int unsigned EVT_CLK_VALID = 3;
    localparam int unsigned EVT_COUNT     = 4;

    typedef enum logic [1:0] {
        RTCX_SRC_SELF,
        RTCX_SRC_CRYSTAL,
        RTCX_SRC_LFO
    } rtcx_osc_src_type;

    typedef enum logic [1:0] {
        RTCX_BUS_IDLE,
        RTCX_BUS_WRITE,
        RTCX_BUS_READ_WAIT,
        RTCX_BUS_READ_DONE
    } rtcx_bus_state_type;

    // drive towards the analog oscillator
    typedef struct packed {
        logic             gain_control_enable;
        logic             bias_double_enable;
        rtcx_osc_src_type source;
        logic             osc_pin_short_select;
        logic [3:0]       load_cap_applied;
    } rtcx_osc_drive_type;

    // requests towards the timer
    typedef struct packed {
        logic        set_req;
        logic        capture_req;
        logic [31:0] load_value;
    } rtcx_timer_req_type;

endpackage : rtcx_pkg

/* File: design/rtcx_cap_step.sv */
// rtcx_cap_step: walks the applied load capacitance towards its target
// assumes the target is a register value, stable between software writes
`timescale 1ns/10ps
module rtcx_cap_step
    import rtcx_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_auto_step,
    input  wire logic [3:0] i_target,
    output logic      [3:0] o_applied,
    output logic            o_ready
);

    logic [3:0]            applied;
    logic [3:0]            next_applied;
    logic [STEP_CNT_W-1:0] pace;
    logic [STEP_CNT_W-1:0] next_pace;

    // one unit closer to the target
    function automatic logic [3:0] step_toward(input logic [3:0] cur,
                                               input logic [3:0] tgt);
        if (cur < tgt) begin
            return 4'(cur + 4'h1);
        end else if (cur > tgt) begin
            return 4'(cur - 4'h1);
        end
        return cur;
    endfunction : step_toward

    // gradual steps when enabled, otherwise the target applies at once
    always_comb begin
        next_applied = applied;
        next_pace    = pace;
        if (!i_auto_step) begin
            next_applied = i_target;        // R1
            next_pace    = '0;
        end else if (applied != i_target) begin
            if (pace == STEP_CNT_W'(CAP_STEP_CYCLES - 1)) begin
                next_applied = step_toward(applied, i_target); // R1
                next_pace    = '0;
            end else begin
                next_pace = STEP_CNT_W'(pace + 1'b1);
            end
        end else begin
            next_pace = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            applied <= RST_LOAD_CAP;
            pace    <= '0;
        end else begin
            applied <= next_applied;
            pace    <= next_pace;
        end
    end

    assign o_applied = applied;
    assign o_ready   = (applied == i_target); // R2

endmodule : rtcx_cap_step

/* File: design/rtcx_osc_regs.sv */
// rtcx_osc_regs: rtc oscillator control, configuration, pin setup and the
// four timer capture bytes, reached over an ahb-lite slave port
// assumes one master, synchronous inputs, and a timer that answers each
// request with a one-cycle done pulse
//
// Contract
// R1: auto stepping moves the applied capacitance stepwise to the target.
// R2: the ready flag is one when applied equals target, zero while stepping.
// R3: configuration bits three to zero hold the read/write target capacitance.
// R4: configuration bits five and four read zero and ignore writes.
// R5: a one in the write-only pin bit shorts the two oscillator pins.
// R6: software changes the pin bit only by read-modify-write.
// R7: four capture bytes form one 32-bit value to read or load the timer.
// R8: bytes move to or from the timer only on a set or capture command.
// R9: a set command loads the bytes into the timer and clears when done.
// R10: a capture command copies the timer into the bytes, clearing when done.
// R11: the lfo override wins, else the mode bit picks crystal or self.
// R12: gain and bias are read/write, clock-valid read-only, bits 2:0 zero.
`timescale 1ns/10ps
module rtcx_osc_regs
    import rtcx_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    // ahb-lite slave
    input  wire logic               i_hsel,
    input  wire logic [31:0]        i_haddr,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [2:0]         i_hsize,
    input  wire logic [31:0]        i_hwdata,
    input  wire logic               i_hready,
    output logic      [31:0]        o_hrdata,
    output logic                    o_hreadyout,
    output logic                    o_hresp,
    // oscillator
    input  wire logic               i_osc_amplitude_ok,
    output rtcx_osc_drive_type      o_osc_drive,
    // timer
    output rtcx_timer_req_type      o_timer_req,
    input  wire logic               i_timer_set_done,
    input  wire logic               i_timer_capture_done,
    input  wire logic [31:0]        i_timer_value,
    // interrupt
    output logic                    o_irq
);

    // bus phase state
    rtcx_bus_state_type   bus_state;
    rtcx_bus_state_type   next_bus_state;
    logic [7:0]           ph_index;
    logic [7:0]           next_ph_index;
    logic                 ph_mapped;
    logic                 next_ph_mapped;
    logic [31:0]          hrdata;
    logic [31:0]          next_hrdata;

    // register state
    logic [7:0]           cap_bytes [0:3];
    logic [7:0]           next_cap_bytes [0:3];
    logic                 set_cmd;
    logic                 next_set_cmd;
    logic                 cap_cmd;
    logic                 next_cap_cmd;
    logic                 gain_control_enable;
    logic                 next_gain_control_enable;
    logic                 crystal_mode_select;
    logic                 next_crystal_mode_select;
    logic                 bias_double_enable;
    logic                 next_bias_double_enable;
    logic                 low_freq_osc_override;
    logic                 next_low_freq_osc_override;
    logic                 cap_auto_step_enable;
    logic                 next_cap_auto_step_enable;
    logic [3:0]           load_cap_target;
    logic [3:0]           next_load_cap_target;
    logic                 osc_pin_short_select;
    logic                 next_osc_pin_short_select;
    logic [6:0]           pin_rsvd;
    logic [6:0]           next_pin_rsvd;
    logic [EVT_COUNT-1:0] irq_status;
    logic [EVT_COUNT-1:0] next_irq_status;
    logic [EVT_COUNT-1:0] irq_mask;
    logic [EVT_COUNT-1:0] next_irq_mask;
    logic                 valid_q;
    logic                 ready_q;

    // derived signals
    logic                 addr_take;
    logic                 wr_en;
    logic [7:0]           wr_data;
    logic [3:0]           load_cap_applied;
    logic                 cap_ready_flag;
    logic [EVT_COUNT-1:0] events;

    // address decode: word index, upper bits must be zero to be mapped
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        return addr[9:2];
    endfunction : reg_index

    function automatic logic index_mapped(input logic [31:0] addr);
        logic [7:0] idx;
        idx = reg_index(addr);
        return (addr[31:10] == 22'h000000) &&
               ((idx <= IDX_OSC_PIN) || (idx == IDX_IRQ_STATUS) ||
                (idx == IDX_IRQ_MASK));
    endfunction : index_mapped

    assign addr_take = i_hsel & i_htrans[1] & i_hready;
    assign wr_en     = (bus_state == RTCX_BUS_WRITE) & ph_mapped;
    assign wr_data   = i_hwdata[7:0];

    // load capacitance stepper
    rtcx_cap_step u_cap_step (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_auto_step (cap_auto_step_enable),
        .i_target    (load_cap_target),
        .o_applied   (load_cap_applied),
        .o_ready     (cap_ready_flag)
    );

    // bus phase sequencing; reads wait one cycle so that a write in the
    // preceding data phase is always seen by the read that follows it
    always_comb begin
        next_bus_state = bus_state;
        next_ph_index  = ph_index;
        next_ph_mapped = ph_mapped;
        next_hrdata    = hrdata;
        case (bus_state)
            RTCX_BUS_READ_WAIT: begin
                next_bus_state = RTCX_BUS_READ_DONE;
                next_hrdata    = '0;
                if (ph_mapped) begin
                    case (ph_index)
                        IDX_TIMER_CAPTURE_BYTE0: next_hrdata[7:0] = cap_bytes[0];
                        IDX_TIMER_CAPTURE_BYTE1: next_hrdata[7:0] = cap_bytes[1];
                        IDX_TIMER_CAPTURE_BYTE2: next_hrdata[7:0] = cap_bytes[2];
                        IDX_TIMER_CAPTURE_BYTE3: next_hrdata[7:0] = cap_bytes[3];
                        IDX_TIMER_CMD: begin
                            next_hrdata[CMD_SET_BIT] = set_cmd;
                            next_hrdata[CMD_CAP_BIT] = cap_cmd;
                        end
                        IDX_OSC_CTRL: begin
                            // bits two to zero stay zero
                            next_hrdata[CTRL_GAIN_BIT]  = gain_control_enable;
                            next_hrdata[CTRL_CRYSTAL_MODE_SELECT_BIT] = crystal_mode_select;
                            next_hrdata[CTRL_BIAS_BIT]  = bias_double_enable;
                            next_hrdata[CTRL_VALID_BIT] = i_osc_amplitude_ok;
                            next_hrdata[CTRL_LFO_BIT]   = low_freq_osc_override;
                        end // R12
                        IDX_OSC_CFG: begin
                            next_hrdata[CFG_STEP_BIT]  = cap_auto_step_enable;
                            next_hrdata[CFG_READY_BIT] = cap_ready_flag; // R2
                            next_hrdata[CFG_CAP_MSB:0] = load_cap_target; // R3
                        end // R4
                        IDX_OSC_PIN: begin
                            // pin bit is write-only and reads as zero
                            next_hrdata[PIN_RSVD_W-1:0] = pin_rsvd;
                        end
                        IDX_IRQ_STATUS: next_hrdata[EVT_COUNT-1:0] = irq_status;
                        IDX_IRQ_MASK:   next_hrdata[EVT_COUNT-1:0] = irq_mask;
                        default:        next_hrdata = '0;
                    endcase
                end
            end
            RTCX_BUS_IDLE, RTCX_BUS_WRITE, RTCX_BUS_READ_DONE: begin
                next_bus_state = RTCX_BUS_IDLE;
                if (addr_take) begin
                    next_ph_index  = reg_index(i_haddr);
                    next_ph_mapped = index_mapped(i_haddr);
                    next_bus_state = i_hwrite ? RTCX_BUS_WRITE
                                              : RTCX_BUS_READ_WAIT;
                end
            end
            default: next_bus_state = RTCX_BUS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_state <= RTCX_BUS_IDLE;
            ph_index  <= 8'h00;
            ph_mapped <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            ph_index  <= next_ph_index;
            ph_mapped <= next_ph_mapped;
            hrdata    <= next_hrdata;
        end
    end

    // oscillator control, configuration and pin fields
    always_comb begin
        next_gain_control_enable   = gain_control_enable;
        next_crystal_mode_select   = crystal_mode_select;
        next_bias_double_enable    = bias_double_enable;
        next_low_freq_osc_override = low_freq_osc_override;
        next_cap_auto_step_enable  = cap_auto_step_enable;
        next_load_cap_target       = load_cap_target;
        next_osc_pin_short_select  = osc_pin_short_select;
        next_pin_rsvd              = pin_rsvd;
        if (wr_en && ph_index == IDX_OSC_CTRL) begin
            next_gain_control_enable   = wr_data[CTRL_GAIN_BIT];  // R12
            next_crystal_mode_select   = wr_data[CTRL_CRYSTAL_MODE_SELECT_BIT];
            next_bias_double_enable    = wr_data[CTRL_BIAS_BIT];  // R12
            // the override is writable so software can pick the lfo
            next_low_freq_osc_override = wr_data[CTRL_LFO_BIT];
        end
        if (wr_en && ph_index == IDX_OSC_CFG) begin
            next_cap_auto_step_enable = wr_data[CFG_STEP_BIT];    // R1
            next_load_cap_target      = wr_data[CFG_CAP_MSB:0];   // R3
        end
        if (wr_en && ph_index == IDX_OSC_PIN) begin
            next_osc_pin_short_select = wr_data[PIN_SHORT_BIT];   // R5
            // reserved bits simply keep what software writes back
            next_pin_rsvd             = wr_data[PIN_RSVD_W-1:0];  // R6
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gain_control_enable   <= RST_CTRL[CTRL_GAIN_BIT];
            crystal_mode_select   <= RST_CTRL[CTRL_CRYSTAL_MODE_SELECT_BIT];
            bias_double_enable    <= RST_CTRL[CTRL_BIAS_BIT];
            low_freq_osc_override <= RST_CTRL[CTRL_LFO_BIT];
            cap_auto_step_enable  <= 1'b0;
            load_cap_target       <= RST_LOAD_CAP;
            osc_pin_short_select  <= 1'b0;
            pin_rsvd              <= RST_PIN_RSVD;
        end else begin
            gain_control_enable   <= next_gain_control_enable;
            crystal_mode_select   <= next_crystal_mode_select;
            bias_double_enable    <= next_bias_double_enable;
            low_freq_osc_override <= next_low_freq_osc_override;
            cap_auto_step_enable  <= next_cap_auto_step_enable;
            load_cap_target       <= next_load_cap_target;
            osc_pin_short_select  <= next_osc_pin_short_select;
            pin_rsvd              <= next_pin_rsvd;
        end
    end

    // capture bytes and timer commands; a done pulse clears its command
    // unless software rewrites a one in that same cycle
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_cap_bytes[i] = cap_bytes[i];
            if (wr_en && ph_index == 8'(i)) begin
                next_cap_bytes[i] = wr_data;
            end
            // timer copy beats a software write in the same cycle
            if (cap_cmd && i_timer_capture_done) begin
                next_cap_bytes[i] = i_timer_value[8*i +: 8]; // R10
            end
        end
        next_set_cmd = set_cmd;
        next_cap_cmd = cap_cmd;
        if (set_cmd && i_timer_set_done) begin
            next_set_cmd = 1'b0;                            // R9
        end
        if (cap_cmd && i_timer_capture_done) begin
            next_cap_cmd = 1'b0;                            // R10
        end
        if (wr_en && ph_index == IDX_TIMER_CMD) begin
            if (wr_data[CMD_SET_BIT]) begin
                next_set_cmd = 1'b1;                        // R9
            end
            if (wr_data[CMD_CAP_BIT]) begin
                next_cap_cmd = 1'b1;                        // R10
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 4; i++) begin
                cap_bytes[i] <= RST_CAPTURE;
            end
            set_cmd <= 1'b0;
            cap_cmd <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cap_bytes[i] <= next_cap_bytes[i];
            end
            set_cmd <= next_set_cmd;
            cap_cmd <= next_cap_cmd;
        end
    end

    // interrupt events: command completions and rising ready/valid flags
    assign events[EVT_SET_DONE]  = set_cmd & i_timer_set_done;
    assign events[EVT_CAP_DONE]  = cap_cmd & i_timer_capture_done;
    assign events[EVT_CAP_READY] = cap_ready_flag & ~ready_q;
    assign events[EVT_CLK_VALID] = i_osc_amplitude_ok & ~valid_q;

    // write-one-to-clear; a new event wins over the clear
    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (wr_en && ph_index == IDX_IRQ_STATUS) begin
            next_irq_status = irq_status & ~wr_data[EVT_COUNT-1:0];
        end
        if (wr_en && ph_index == IDX_IRQ_MASK) begin
            next_irq_mask = wr_data[EVT_COUNT-1:0];
        end
        next_irq_status = next_irq_status | events;
    end

    // ready starts high after reset, so no event fires on release
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_status <= RST_IRQ;
            irq_mask   <= RST_IRQ;
            valid_q    <= 1'b0;
            ready_q    <= 1'b1;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            valid_q    <= i_osc_amplitude_ok;
            ready_q    <= cap_ready_flag;
        end
    end

    // oscillator source: lfo override first, then crystal or self
    always_comb begin
        o_osc_drive.gain_control_enable  = gain_control_enable;
        o_osc_drive.bias_double_enable   = bias_double_enable;
        o_osc_drive.osc_pin_short_select = osc_pin_short_select; // R5
        o_osc_drive.load_cap_applied     = load_cap_applied;
        if (low_freq_osc_override) begin
            o_osc_drive.source = RTCX_SRC_LFO;                     // R11
        end else if (crystal_mode_select) begin
            o_osc_drive.source = RTCX_SRC_CRYSTAL;                 // R11
        end else begin
            o_osc_drive.source = RTCX_SRC_SELF;                    // R11
        end
    end

    // timer always sees the capture bytes; set and capture requests follow the pending commands
    assign o_timer_req.set_req     = set_cmd;                      // R8
    assign o_timer_req.capture_req = cap_cmd;                      // R8
    assign o_timer_req.load_value  = {cap_bytes[3], cap_bytes[2],
                                      cap_bytes[1], cap_bytes[0]}; // R7

    assign o_hrdata    = hrdata;
    assign o_hreadyout = (bus_state != RTCX_BUS_READ_WAIT);
    assign o_hresp     = 1'b0;
    assign o_irq       = |(irq_status & irq_mask);

endmodule : rtcx_osc_regs

/* File: tb/rtcx_osc_regs_sva.sv */
// rtcx_osc_regs_sva: port-level checks of the rtc oscillator register block
// assumes one ahb-lite master and a timer that pulses done once per request
`timescale 1ns/10ps
module rtcx_osc_regs_sva
    import rtcx_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_hsel,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [31:0]        i_hwdata,
    input  wire logic               i_hready,
    input  wire logic [31:0]        o_hrdata,
    input  wire logic               o_hreadyout,
    input  wire rtcx_osc_drive_type o_osc_drive,
    input  wire rtcx_timer_req_type o_timer_req,
    input  wire logic               i_timer_set_done,
    input  wire logic               i_timer_capture_done,
    input  wire logic               o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a transfer is taken only when the bus is ready
    logic take;
    assign take = i_hsel & i_htrans[1] & i_hready;

    a_read_wait: assert property (take && !i_hwrite |=>
        !o_hreadyout ##1 o_hreadyout) else $error("read wait wrong");
    a_write_nowait: assert property (take && i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    a_rdata_byte: assert property (o_hreadyout |->
        o_hrdata[31:8] == 24'h0) else $error("upper read bits set");
    a_set_cause: assert property ($rose(o_timer_req.set_req) |->
        $past(i_hwdata[CMD_SET_BIT])) else $error("set without write");
    a_set_clear: assert property (o_timer_req.set_req &&
        i_timer_set_done |=> !o_timer_req.set_req) else $error("set stuck");
    a_cap_clear: assert property (o_timer_req.capture_req &&
        i_timer_capture_done |=> !o_timer_req.capture_req)
        else $error("capture stuck");
    a_load_hold: assert property (o_timer_req.set_req &&
        !i_timer_set_done |=> $stable(o_timer_req.load_value))
        else $error("load value moved");
    a_src_legal: assert property (o_osc_drive.source != 2'h3)
        else $error("bad source");
    c_set: cover property (o_timer_req.set_req && i_timer_set_done);
    c_cap: cover property (o_timer_req.capture_req && i_timer_capture_done);
    c_irq: cover property ($rose(o_irq));
endmodule : rtcx_osc_regs_sva

bind rtcx_osc_regs rtcx_osc_regs_sva i_rtcx_osc_regs_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_osc_drive(o_osc_drive), .o_timer_req(o_timer_req),
    .i_timer_set_done(i_timer_set_done), .o_irq(o_irq),
    .i_timer_capture_done(i_timer_capture_done));

/* File: tb/test_rtcx_osc_regs.sv */
// test_rtcx_osc_regs: directed register-level bench for rtcx_osc_regs
// assumes the bench alone is bus master, timer and oscillator
`timescale 1ns/10ps
module test_rtcx_osc_regs
    import rtcx_pkg::*;
;
    logic               i_clk, i_rst_n, hsel, hwrite, amp_ok;
    logic               set_done, cap_done, hreadyout, irq, hresp;
    logic [1:0]         htrans;
    logic [31:0]        haddr, hwdata, tvalue, hrdata, rd;
    rtcx_osc_drive_type drive;
    rtcx_timer_req_type req;
    int                 mismatches, n_compared;
    logic [7:0]         cw [3] = '{8'hFF, 8'h40, 8'h00};

    rtcx_osc_regs i_rtcx_osc_regs (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .i_osc_amplitude_ok(amp_ok),
        .o_osc_drive(drive), .o_timer_req(req), .i_timer_set_done(set_done),
        .i_timer_capture_done(cap_done), .i_timer_value(tvalue), .o_irq(irq));

    // free-running 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            $display("MISMATCH t=%0t bus hang", $time);
            end_sim();
        end
    endtask : wait_rdy

    // one single word transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge i_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        #1;
    endtask : bus

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask : rdc

    // one-cycle done pulse from the timer side
    task automatic pulse(input logic s);
        @(posedge i_clk);
        set_done <= s;
        cap_done <= ~s;
        @(posedge i_clk);
        set_done <= 1'b0;
        cap_done <= 1'b0;
        #1;
    endtask : pulse

    // main sequence; irq checks last so every event bit has fired
    initial begin
        {i_rst_n, hsel, hwrite, amp_ok, set_done, cap_done} = 6'h00;
        {htrans, haddr, hwdata} = '0;
        tvalue = 32'hA5C30F96;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rdc(i[7:0], i == 6 ? 32'h40 : 32'h0);
        @(posedge i_clk);
        amp_ok <= 1'b1;
        foreach (cw[k]) begin
            bus(1'b1, IDX_OSC_CTRL, {24'h0, cw[k]});
            rdc(IDX_OSC_CTRL, {24'h0, cw[k] & 8'hE8 | 8'h10});
            check({28'h0, drive[8:5]}, {28'h0, cw[k][7], cw[k][5],
                cw[k][3] ? 2'h2 : {1'b0, cw[k][6]}});
        end
        bus(1'b1, IDX_OSC_CFG, 32'h3F);
        rdc(IDX_OSC_CFG, 32'h4F);
        bus(1'b1, IDX_OSC_CFG, 32'h85);
        rdc(IDX_OSC_CFG, 32'h85);
        repeat (50) @(posedge i_clk);
        check({28'h0, drive.load_cap_applied}, 32'hF);
        repeat (1100) @(posedge i_clk);
        rdc(IDX_OSC_CFG, 32'hC5);
        rdc(IDX_OSC_PIN, 32'h0);
        bus(1'b1, IDX_OSC_PIN, {24'h0, rd[7:0] | 8'h80});
        check({31'h0, drive.osc_pin_short_select}, 32'h1);
        rdc(IDX_OSC_PIN, 32'h0);
        bus(1'b1, IDX_OSC_PIN, 32'h2A);
        rdc(IDX_OSC_PIN, 32'h2A);
        check({31'h0, drive.osc_pin_short_select}, 32'h0);
        for (int b = 0; b < 4; b++) bus(1'b1, b[7:0], 32'h11 * (b + 1));
        bus(1'b1, IDX_TIMER_CMD, 32'h2);
        check(req.load_value, 32'h44332211);
        rdc(IDX_TIMER_CMD, 32'h2);
        pulse(1'b1);
        rdc(IDX_TIMER_CMD, 32'h0);
        bus(1'b1, IDX_TIMER_CMD, 32'h1);
        rdc(IDX_TIMER_CAPTURE_BYTE0, 32'h11);
        pulse(1'b0);
        check({31'h0, req.capture_req}, 32'h0);
        for (int b = 0; b < 4; b++) rdc(8'(b), {24'h0, tvalue[8*b+:8]});
        bus(1'b1, 8'h20, 32'hFF);
        rdc(8'h20, 32'h0);
        check({31'h0, irq}, 32'h0);
        rdc(IDX_IRQ_STATUS, 32'hF);
        bus(1'b1, IDX_IRQ_MASK, 32'h3);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, IDX_IRQ_STATUS, 32'h3);
        check({31'h0, irq}, 32'h0);
        rdc(IDX_IRQ_STATUS, 32'hC);
        end_sim();
    end
endmodule : test_rtcx_osc_regs
